// ---- src/ssc_defines.svh ----
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define SSC_IDX_CTRL 6'h20
`define SSC_IDX_STAT 6'h21
`define SSC_IDX_RXB 6'h22
`define SSC_IDX_TXB 6'h23
`define SSC_IDX_CFG 6'h24

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define SSC_CTRL_RUN 7
`define SSC_CTRL_ABORT 6
`define SSC_CTRL_MODE_HI 5
`define SSC_CTRL_MODE_LO 4
`define SSC_CTRL_DIR 3
`define SSC_CTRL_SCK_HI 2
`define SSC_CTRL_SCK_LO 0
`define SSC_CTRL_RST 8'h00

// ----------------------------------------------------------------
// Status register fields and reset value
// ----------------------------------------------------------------
`define SSC_STAT_TXERR 3
`define SSC_STAT_RXERR 2
`define SSC_STAT_RST 8'h20

// ----------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------
`define SSC_CFG_DIVSRC 0
`define SSC_CFG_SLOW 1

// ----------------------------------------------------------------
// Serial clock codes and divider exponents (period = 2^exp)
// ----------------------------------------------------------------
`define SSC_SCK_EXT 3'h7
`define SSC_SCK_FS 3'h0
`define SSC_EXP_C0 12
`define SSC_EXP_C1 8
`define SSC_EXP_C2 7
`define SSC_EXP_C3 6
`define SSC_EXP_C4 5
`define SSC_EXP_C5 4
`define SSC_EXP_C6 3
`define SSC_FS_HALF 4'h8
`define SSC_BITS_LAST 3'h7

`endif

// ---- src/ssc_pkg.sv ----
`default_nettype none

package ssc_pkg;

	// Transfer mode field, codes 00, 01, 10, 11 in order
	typedef enum logic [1:0] {SSC_MODE_TX, SSC_MODE_RX, SSC_MODE_TRX, SSC_MODE_RSV} ssc_mode_t;

	// Shift engine states
	typedef enum logic [1:0] {SSC_ST_IDLE, SSC_ST_GAP, SSC_ST_SHIFT} ssc_state_t;

	// Rate generator state
	typedef struct packed {
		logic [10:0] cnt;
		logic tick;
	} ssc_gen_t;

	// Whole state of the top module
	typedef struct packed {
		logic run;
		logic abort;
		ssc_mode_t mode;
		logic lsb_first;
		logic [2:0] sck_sel;
		logic div_src;
		logic slow;
		ssc_state_t st;
		logic [2:0] cnt;
		logic [7:0] sh;
		logic [7:0] rxbuf;
		logic [7:0] txbuf;
		logic txf;
		logic rxf;
		logic txerr;
		logic rxerr;
		logic sck;
		logic so;
		logic sck_in_d;
		logic ack;
		logic [31:0] rdata;
	} ssc_top_t;

endpackage : ssc_pkg

`default_nettype wire

// ---- src/ssc_clkgen.sv ----
`include "ssc_defines.svh"
`default_nettype none

// Internal serial clock rate generator: one tick per half period
module ssc_clkgen
	import ssc_pkg::*;
#(
	parameter int CNT_W = 11
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [2:0] sel,
	input wire logic div_src,
	input wire logic slow,
	input wire logic fs_tick,
	output logic tick
);

	ssc_gen_t g_r;
	ssc_gen_t g_nxt;
	logic fs_mode;
	logic valid;

	// ------------------------------------------------------------
	// Half-period terminal count for a code
	// ------------------------------------------------------------
	function automatic logic [CNT_W-1:0] half_term(input logic [2:0] code);
		int e;
		case (code)
			3'h0: e = `SSC_EXP_C0;
			3'h1: e = `SSC_EXP_C1;
			3'h2: e = `SSC_EXP_C2;
			3'h3: e = `SSC_EXP_C3;
			3'h4: e = `SSC_EXP_C4;
			3'h5: e = `SSC_EXP_C5;
			default: e = `SSC_EXP_C6;
		endcase
		half_term = CNT_W'((32'h1 << (e - 1)) - 32'h1);
	endfunction : half_term

	// ------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------
	// Code 000 runs from the slow clock when selected or in slow mode
	assign fs_mode = (sel == `SSC_SCK_FS) && (div_src || slow);
	assign valid = (sel != `SSC_SCK_EXT) && !(slow && sel != `SSC_SCK_FS);

	// Counter restarts on every start so the first half period is full
	always_comb
	begin
		g_nxt = g_r;
		g_nxt.tick = 1'b0;
		if (!run || !valid)
		begin
			g_nxt.cnt = '0;
		end
		else if (fs_mode)
		begin
			if (fs_tick)
			begin
				if (g_r.cnt == CNT_W'(`SSC_FS_HALF - 4'h1))
				begin
					g_nxt.cnt = '0;
					g_nxt.tick = 1'b1;
				end
				else
				begin
					g_nxt.cnt = g_r.cnt + CNT_W'(1);
				end
			end
		end
		else if (g_r.cnt == half_term(sel))
		begin
			g_nxt.cnt = '0;
			g_nxt.tick = 1'b1;
		end
		else
		begin
			g_nxt.cnt = g_r.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			g_r <= '0;
		else
			g_r <= g_nxt;
	end

	assign tick = g_r.tick;

endmodule : ssc_clkgen

`default_nettype wire

// ---- src/ssc_top.sv ----
`include "ssc_defines.svh"
`default_nettype none

module ssc_top
	import ssc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic fs_tick,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe_n,
	output logic transfer_active
);

	ssc_top_t s_r;
	ssc_top_t s_nxt;
	logic gen_tick;
	logic [5:0] idx;
	logic acc;
	logic wr;
	logic rd;
	logic ext;
	logic fall;
	logic rise;
	logic tx_en;
	logic rx_en;
	logic ready;
	logic [7:0] ld;
	logic [7:0] nsh;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// bit presented on the output pin
	function automatic logic out_bit(input logic [7:0] v, input logic lsb);
		out_bit = lsb ? v[0] : v[7];
	endfunction : out_bit

	// shift one received bit into the byte
	function automatic logic [7:0] shift_in(input logic [7:0] v, input logic lsb,
		input logic b);
		shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
	endfunction : shift_in

	// ------------------------------------------------------------
	// Rate generator
	// ------------------------------------------------------------
	ssc_clkgen #(
		.CNT_W(11)
	) u_gen (
		.ref_clk(ref_clk),
		.rst(rst),
		.run(s_r.st != SSC_ST_IDLE),
		.sel(s_r.sck_sel),
		.div_src(s_r.div_src),
		.slow(s_r.slow),
		.fs_tick(fs_tick),
		.tick(gen_tick)
	);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	// One wait state: the request is taken on its second edge
	assign acc = (read || write) && s_r.ack;
	assign wr = write && acc && byteenable[0];
	assign rd = read && acc;
	assign idx = address[7:2];
	assign ext = (s_r.sck_sel == `SSC_SCK_EXT);
	// mode decode; reserved code moves no data
	assign tx_en = (s_r.mode == SSC_MODE_TX) || (s_r.mode == SSC_MODE_TRX);
	assign rx_en = (s_r.mode == SSC_MODE_RX) || (s_r.mode == SSC_MODE_TRX);
	// Auto-wait: internal clock holds until buffers can follow
	assign ready = (!tx_en || !s_r.txf) && (!rx_en || !s_r.rxf);
	// edges come from the pin when external, else from ticks
	assign fall = ext ? (s_r.sck_in_d && !serial_clock_pin_in) : (gen_tick && s_r.sck);
	assign rise = ext ? (!s_r.sck_in_d && serial_clock_pin_in) : (gen_tick && !s_r.sck);
	// Byte to shift out: fresh buffer when present, else the shift register as it stands (underrun)
	assign ld = (tx_en && !s_r.txf) ? s_r.txbuf : s_r.sh;
	assign nsh = shift_in(s_r.sh, s_r.lsb_first, serial_in_pin);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Bus effects go first so hardware sets below win over clears
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.abort = 1'b0;
		s_nxt.ack = (read || write) && !s_r.ack;
		s_nxt.sck_in_d = serial_clock_pin_in;

		// Read data is captured in the wait cycle and held
		if (read && !s_r.ack)
		begin
			case (idx)
				`SSC_IDX_CTRL:
					s_nxt.rdata = {24'h000000, s_r.run, s_r.abort, s_r.mode,
						s_r.lsb_first, s_r.sck_sel};
				`SSC_IDX_STAT:
					s_nxt.rdata = {24'h000000, s_r.st != SSC_ST_IDLE,
						s_r.cnt != 3'h0, s_r.txf, s_r.rxf, s_r.txerr, s_r.rxerr, 2'h0};
				`SSC_IDX_RXB:
					s_nxt.rdata = {24'h000000, s_r.rxbuf};
				`SSC_IDX_CFG:
					s_nxt.rdata = {30'h00000000, s_r.slow, s_r.div_src};
				default:
					s_nxt.rdata = 32'h00000000;
			endcase
		end

		// Register writes
		if (wr)
		begin
			case (idx)
				`SSC_IDX_CTRL:
				begin
					s_nxt.run = writedata[`SSC_CTRL_RUN];
					// setup fields trusted to change only while idle
					s_nxt.mode = ssc_mode_t'(writedata[`SSC_CTRL_MODE_HI:`SSC_CTRL_MODE_LO]);
					s_nxt.lsb_first = writedata[`SSC_CTRL_DIR];
					s_nxt.sck_sel = writedata[`SSC_CTRL_SCK_HI:`SSC_CTRL_SCK_LO];
				end
				`SSC_IDX_STAT:
				begin
					// Error flags clear on 0, writing 1 is ignored
					if (!writedata[`SSC_STAT_TXERR])
						s_nxt.txerr = 1'b0;
					if (!writedata[`SSC_STAT_RXERR])
						s_nxt.rxerr = 1'b0;
				end
				`SSC_IDX_TXB:
				begin
					// Write lost when the buffer is still full
					if (s_r.txf)
					begin
						s_nxt.txbuf = writedata[7:0];
						s_nxt.txf = 1'b0;
					end
				end
				`SSC_IDX_CFG:
				begin
					s_nxt.div_src = writedata[`SSC_CFG_DIVSRC];
					s_nxt.slow = writedata[`SSC_CFG_SLOW];
				end
				default:
					s_nxt.run = s_r.run;
			endcase
		end

		// Reading the receive buffer frees it
		if (rd && idx == `SSC_IDX_RXB)
			s_nxt.rxf = 1'b0;

		// Shift engine
		case (s_r.st)
			SSC_ST_IDLE:
			begin
				s_nxt.sck = 1'b1;
				s_nxt.cnt = 3'h0;
				if (s_r.run)
					s_nxt.st = SSC_ST_GAP;
			end
			SSC_ST_GAP:
			begin
				// stop between bytes when run is low
				if (!s_r.run)
					s_nxt.st = SSC_ST_IDLE;
				else if (fall && (ext || ready))
				begin
					if (tx_en)
					begin
						if (s_r.txf)
							s_nxt.txerr = 1'b1;
						s_nxt.txf = 1'b1;
					end
					s_nxt.sh = ld;
					s_nxt.so = tx_en ? out_bit(ld, s_r.lsb_first) : 1'b1;
					s_nxt.sck = 1'b0;
					s_nxt.st = SSC_ST_SHIFT;
				end
			end
			SSC_ST_SHIFT:
			begin
				// Leading edge drives the next bit
				if (fall)
				begin
					s_nxt.so = tx_en ? out_bit(s_r.sh, s_r.lsb_first) : 1'b1;
					s_nxt.sck = 1'b0;
				end
				// Trailing edge samples the input
				if (rise)
				begin
					s_nxt.sck = 1'b1;
					s_nxt.sh = nsh;
					s_nxt.cnt = s_r.cnt + 3'h1;
					if (s_r.cnt == `SSC_BITS_LAST)
					begin
						// Byte complete; overrun keeps the old buffer
						if (rx_en)
						begin
							if (s_r.rxf && !(rd && idx == `SSC_IDX_RXB)) // read now frees it
								s_nxt.rxerr = 1'b1;
							else
							begin
								s_nxt.rxbuf = nsh;
								s_nxt.rxf = 1'b1;
							end
						end
						s_nxt.cnt = 3'h0;
						s_nxt.st = SSC_ST_GAP;
					end
				end
			end
			default:
				s_nxt.st = SSC_ST_IDLE;
		endcase

		// forced abort wins over everything this cycle
		if (wr && idx == `SSC_IDX_CTRL && writedata[`SSC_CTRL_ABORT])
		begin
			s_nxt.abort = 1'b1;
			s_nxt.st = SSC_ST_IDLE;
			s_nxt.cnt = 3'h0;
			s_nxt.sh = 8'h00;
			s_nxt.sck = 1'b1;
			s_nxt.so = 1'b1;
			s_nxt.run = 1'b0;
			s_nxt.txf = 1'b1;
			s_nxt.rxf = 1'b0;
			s_nxt.txerr = 1'b0;
			s_nxt.rxerr = 1'b0;
			s_nxt.rxbuf = 8'h00;
			s_nxt.txbuf = 8'h00;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Status reset leaves the transmit buffer marked empty
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			s_r <= '0;
			s_r.txf <= 1'b1;
			s_r.sck <= 1'b1;
			s_r.so <= 1'b1;
			s_r.sck_in_d <= 1'b1;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// pins assume the shared port latches are already high
	assign waitrequest = (read || write) && !s_r.ack;
	assign readdata = s_r.rdata;
	assign serial_out_pin = s_r.so;
	assign serial_clock_pin_out = s_r.sck;
	// release the clock pin when the far side drives it
	assign serial_clock_pin_oe_n = ext;
	assign transfer_active = (s_r.st != SSC_ST_IDLE);

endmodule : ssc_top

`default_nettype wire

// ---- dv/ssc_top_assertions.sv ----
`default_nettype none
// ------------------------------------------
// Port checker
// ------------------------------------------
module ssc_top_assertions
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] address,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	input wire logic waitrequest,
	input wire logic serial_clock_pin_out,
	input wire logic serial_clock_pin_oe_n,
	input wire logic transfer_active
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] sel_r;
	logic [11:0] lo_r;
	logic [11:0] hi_r;
	logic wr_ctl;
	logic [11:0] half;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Accepted control write and the half period its code asks for
	assign wr_ctl = write && !waitrequest && address[7:2] == 6'h20 && byteenable[0];
	assign half = 12'h001 << (4'h8 - {1'b0, sel_r});
	// Level timers saturate so a long idle cannot wrap them
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			sel_r <= 3'h0;
			lo_r <= 12'h000;
			hi_r <= 12'h000;
		end
		else
		begin
			if (wr_ctl)
				sel_r <= writedata[2:0];
			lo_r <= serial_clock_pin_out ? 12'h000 : lo_r + {11'h0, lo_r != 12'hFFF};
			hi_r <= !serial_clock_pin_out ? 12'h000 : hi_r + {11'h0, hi_r != 12'hFFF};
		end
	end
	start_run_a: assert property (wr_ctl && writedata[7] && !writedata[6]
		|-> ##[1:3] transfer_active) else $error("run bit did not start engine");
	clock_idle_a: assert property (!transfer_active && $past(!transfer_active)
		&& !serial_clock_pin_oe_n |-> serial_clock_pin_out) else $error("clock low while idle");
	abort_stop_a: assert property (wr_ctl && writedata[6]
		|-> ##[1:2] !transfer_active) else $error("abort did not stop");
	abort_hold_a: assert property (wr_ctl && writedata[6]
		|-> ##2 (!transfer_active) [*3]) else $error("engine restarted after abort");
	ext_oe_a: assert property (!wr_ctl && !$past(wr_ctl) && !$past(wr_ctl, 2)
		|-> serial_clock_pin_oe_n == (sel_r == 3'h7)) else $error("clock enable wrong");
	low_time_a: assert property ($rose(serial_clock_pin_out) && transfer_active
		&& !serial_clock_pin_oe_n && sel_r != 3'h0 |-> lo_r == half)
		else $error("clock low time wrong");
	high_time_a: assert property ($fell(serial_clock_pin_out)
		&& !serial_clock_pin_oe_n && sel_r != 3'h0 |-> hi_r >= half)
		else $error("clock high time short");
endmodule : ssc_top_assertions
`default_nettype wire

// ---- dv/ssc_peer.sv ----
`default_nettype none
// ------------------------------------------
// Far-side serial device
// ------------------------------------------
module ssc_peer
(
	input wire logic clk,
	input wire logic arm,
	input wire logic ext_go,
	input wire logic [7:0] send,
	input wire logic sck_out,
	input wire logic oe_n,
	input wire logic so,
	output logic si,
	output logic sck_in,
	output logic [7:0] cap,
	output logic [3:0] nbits
);
	timeunit 1ns;
	timeprecision 1ns;
	logic e_d = 1'b1;
	logic [4:0] tg = 5'h00;
	logic [2:0] hc = 3'h0;
	logic e;
	initial si = 1'b1;
	initial sck_in = 1'b1;
	initial cap = 8'h00;
	initial nbits = 4'h0;
	assign e = oe_n ? sck_in : sck_out;
	// Shift out MSB first at falls, capture at rises; data inverts once held out
	always @(posedge clk)
	begin
		e_d <= e;
		if (arm)
			nbits <= 4'h0;
		else if (e_d && !e)
			si <= send[3'h7 - nbits[2:0]];
		else if (!e_d && e && nbits != 4'h8)
		begin
			cap <= {cap[6:0], so};
			nbits <= nbits + 4'h1;
			if (nbits == 4'h7)
				si <= ~si;
		end
		// External clock: 8 pulses, 8 cycles per half, well above the minimum width
		if (ext_go)
			tg <= 5'h10;
		else if (tg != 5'h00)
		begin
			hc <= hc + 3'h1;
			if (hc == 3'h7)
			begin
				sck_in <= ~sck_in;
				tg <= tg - 5'h01;
			end
		end
	end
endmodule : ssc_peer
`default_nettype wire

// ---- dv/sync_serial_control_test.sv ----
`default_nettype none
// ------------------------------------------
// Bench
// ------------------------------------------
module sync_serial_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic fs_tick = 1'b0;
	logic si, so, sck_in, sck_out, oe_n, act;
	logic arm = 1'b0;
	logic ext_go = 1'b0;
	logic [7:0] send = 8'h00;
	logic [7:0] cap, q;
	logic [3:0] nbits;
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	logic [7:0] t_adr [5] = '{8'h80, 8'h84, 8'h88, 8'h90, 8'hFC};
	logic [7:0] t_rst [5] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
	// Last row is the reserved mode: clocks run, nothing is sent or kept
	logic [7:0] t_cfg [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
	logic [7:0] t_ctl [6] = '{8'h86, 8'h95, 8'hAE, 8'h80, 8'h87, 8'hB3};
	logic [7:0] t_tx [6] = '{8'hA5, 8'h00, 8'h1E, 8'h81, 8'h96, 8'h00};
	logic [7:0] t_snd [6] = '{8'h00, 8'h5A, 8'hC4, 8'h00, 8'h00, 8'h5A};
	logic [7:0] t_cap [6] = '{8'hA5, 8'h00, 8'h78, 8'h81, 8'h96, 8'hFF};
	logic [7:0] t_rx [6] = '{8'h00, 8'h5A, 8'h23, 8'h23, 8'h23, 8'h23};
	ssc_top DUT (.ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .fs_tick(fs_tick), .serial_in_pin(si),
		.serial_out_pin(so), .serial_clock_pin_in(sck_in), .serial_clock_pin_out(sck_out),
		.serial_clock_pin_oe_n(oe_n), .transfer_active(act));
	ssc_peer peer (.clk(ref_clk), .arm(arm), .ext_go(ext_go), .send(send), .sck_out(sck_out),
		.oe_n(oe_n), .so(so), .si(si), .sck_in(sck_in), .cap(cap), .nbits(nbits));
	always #4 ref_clk = ~ref_clk;
	// Cycle count, low-rate tick every fourth cycle, hang cut-off
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		fs_tick <= (cyc % 4 == 3);
		if (cyc == 40000)
		begin
			fail_count++;
			summarize();
		end
	end
	task check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	// One Avalon transfer: request held until waitrequest is seen low at a rising edge
	task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		address <= a;
		writedata <= {24'h0, d};
		byteenable <= 4'h1;
		write <= wr;
		read <= !wr;
		@(posedge ref_clk);
		while (waitrequest !== 1'b0)
			@(posedge ref_clk);
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task rd(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(q, exp);
	endtask : rd
	// Waits have no timeout of their own; a hung wait ends only at the bench's cycle ceiling, which counts as a failure
	task wait_idle();
		while (act !== 1'b0)
			@(posedge ref_clk);
	endtask : wait_idle
	task wait_bits(input logic [3:0] k);
		while (nbits !== k)
			@(posedge ref_clk);
	endtask : wait_bits
	task arm_peer(input logic [7:0] b);
		send <= b;
		arm <= 1'b1;
		@(posedge ref_clk);
		arm <= 1'b0;
	endtask : arm_peer
	task summarize();
		$display("fail_count=%0d checked=%0d", fail_count, checked);
		if (fail_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	initial
	begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		bus(1'b1, 8'hFC, 8'hFF);
		for (int i = 0; i < 5; i++)
			rd(t_adr[i], t_rst[i]);
		$display("reset test done");
		// Each mode, order and clock source; the transmit buffer is not written in receive-only or reserved mode
		for (int i = 0; i < 6; i++)
		begin
			wait_idle();
			bus(1'b1, 8'h90, t_cfg[i]);
			if (!t_ctl[i][4])
				bus(1'b1, 8'h8C, t_tx[i]);
			arm_peer(t_snd[i]);
			bus(1'b1, 8'h80, t_ctl[i]);
			ext_go <= (t_ctl[i][2:0] == 3'h7);
			@(posedge ref_clk);
			ext_go <= 1'b0;
			wait_bits(4'h8);
			bus(1'b1, 8'h80, t_ctl[i] & 8'h7F);
			wait_idle();
			if (t_ctl[i][5:4] != 2'b01)
				check(cap, t_cap[i]);
			rd(8'h88, t_rx[i]);
			rd(8'h84, 8'h20);
			check({7'h0, oe_n}, {7'h0, t_ctl[i][2:0] == 3'h7});
			$display("transfer test %0d done", i);
		end
		// Abort in mid-byte on the slow internal rate
		bus(1'b1, 8'h8C, 8'h55);
		arm_peer(8'h00);
		bus(1'b1, 8'h80, 8'h81);
		wait_bits(4'h2);
		bus(1'b1, 8'h80, 8'h40);
		rd(8'h80, 8'h00);
		rd(8'h84, 8'h20);
		rd(8'h88, 8'h00);
		check({7'h0, act}, 8'h00);
		$display("abort test done");
		// External clock with empty transmit buffer, then a second byte onto a full receive buffer
		bus(1'b1, 8'h90, 8'h00);
		arm_peer(8'h3C);
		bus(1'b1, 8'h80, 8'hA7);
		for (int k = 0; k < 2; k++)
		begin
			if (k == 1)
				arm_peer(8'h0F);
			ext_go <= 1'b1;
			@(posedge ref_clk);
			ext_go <= 1'b0;
			wait_bits(4'h8);
			check(cap, (k == 1) ? 8'h3C : 8'h00);
		end
		bus(1'b1, 8'h80, 8'h27);
		wait_idle();
		rd(8'h84, 8'h3C);
		rd(8'h88, 8'h3C);
		bus(1'b1, 8'h84, 8'h00);
		rd(8'h84, 8'h20);
		$display("error test done");
		summarize();
	end
endmodule : sync_serial_control_test
bind ssc_top ssc_top_assertions u_chk (.ref_clk, .rst, .address, .write, .byteenable,
	.writedata, .waitrequest, .serial_clock_pin_out, .serial_clock_pin_oe_n, .transfer_active);
`default_nettype wire
